// ### rtl/plwd_div.sv
// Tick counting divider: wrap pulse and glitch-free square wave
`default_nettype none
module plwd_div (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_run,
  input  wire logic                    i_tick,
  input  wire logic [plwd_pkg::CNT_W-1:0] i_limit,
  output logic                         o_pulse,
  output logic                         o_wave
);
  import plwd_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             pulse;
    logic             wave;
  } plwd_div_s;

  plwd_div_s st_r;
  plwd_div_s st_nxt;
  logic      wrap;

  // Wrap at or past the limit, so a shrinking limit never stretches a phase
  assign wrap = i_tick && (st_r.cnt >= (i_limit - ONE_CNT));

  always_comb begin
    st_nxt       = st_r;
    st_nxt.pulse = 1'b0;
    if (!i_run) begin
      st_nxt.cnt  = '0;
      st_nxt.wave = 1'b0;
    end else if (wrap) begin
      st_nxt.cnt   = '0;
      st_nxt.pulse = 1'b1;
      st_nxt.wave  = ~st_r.wave;
    end else if (i_tick) begin
      st_nxt.cnt = st_r.cnt + ONE_CNT;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_pulse = st_r.pulse;
  assign o_wave  = st_r.wave;

  property p_div_wrap;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_run && wrap) |=> (o_pulse && (o_wave != $past(o_wave)) && st_r.cnt == '0);
  endproperty
  a_div_wrap: assert property (p_div_wrap) else $error("divider missed its wrap");
endmodule
`default_nettype wire

// ### rtl/plwd_pkg.sv
// Package: register map, field layout, timing and carrier types of the loop supervisor block
`default_nettype none
package plwd_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int CNT_W  = 8;
  localparam int IRQ_W  = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_LOOP_ENABLE = 16'hf003;
  localparam logic [ADDR_W-1:0] ADDR_LOCK_STATUS = 16'hf004;
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_OUTPUT_PIN_CFG  = 16'hf005;
  localparam logic [ADDR_W-1:0] ADDR_SUPV_CTRL   = 16'hf006;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = 16'hf0e0;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK    = 16'hf0e1;

  // Field positions
  localparam int BIT_LOOP_ENABLE = 0;
  localparam int BIT_LOCK        = 0;
  localparam int BIT_OUT_ENABLE  = 0;
  localparam int RATE_LSB        = 1;
  localparam int RATE_MSB        = 2;
  localparam int BIT_SUPV_ENABLE = 0;
  localparam int IRQ_LOCK_GAIN   = 0;
  localparam int IRQ_LOCK_LOSS   = 1;
  localparam int IRQ_SUPV_RESET  = 2;

  // Reset values
  localparam logic [DATA_W-1:0] RST_LOOP_ENABLE = 16'h0000;
  localparam logic [DATA_W-1:0] RST_LOCK_STATUS = 16'h0000;
  localparam logic [DATA_W-1:0] RST_CLOCK_OUTPUT_PIN_CFG  = 16'h0000;
  localparam logic [DATA_W-1:0] RST_SUPV_CTRL   = 16'h0001;
  localparam logic [IRQ_W-1:0]  RST_IRQ         = 3'h0;

  // Timing at 125 MHz
  localparam int SYS_PERIOD_PS  = 8000;
  localparam int LOCK_SETTLE_NS = 1000;
  localparam int SUPV_RESET_NS  = 64;
  localparam int LOCK_SETTLE_CYC_I = (LOCK_SETTLE_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam int SUPV_RESET_CYC_I  = (SUPV_RESET_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam logic [CNT_W-1:0] LOCK_SETTLE_CYC = CNT_W'(LOCK_SETTLE_CYC_I);
  localparam logic [CNT_W-1:0] SUPV_RESET_CYC  = CNT_W'(SUPV_RESET_CYC_I);
  // System clocks per half period of the times-one output rate
  localparam logic [CNT_W-1:0] REF_HALF_CYC = 8'h30;
  localparam logic [CNT_W-1:0] ONE_CNT      = 8'h01;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } plwd_bus_s;

  typedef struct packed {
    logic ref_present;
    logic settings_ok;
    logic settled;
    logic unstable;
  } plwd_loop_s;

  typedef enum logic [1:0] {
    SUPV_WATCH,
    SUPV_RESET,
    SUPV_RETRY
  } plwd_supv_e;

  typedef struct packed {
    logic              enable;
    logic [1:0]        pend_rate;
    logic              pend_oe;
    logic [1:0]        act_rate;
    logic              act_oe;
    logic [1:0]        act_pred;
    logic              supv_en;
    logic              lock;
    logic [CNT_W-1:0]  settle;
    logic [IRQ_W-1:0]  stat;
    logic [IRQ_W-1:0]  mask;
    logic              irq;
    logic [DATA_W-1:0] rd_data;
    logic              oe;
    logic              mclk_prev;
  } plwd_core_s;
endpackage
`default_nettype wire

// ### rtl/plwd_supv.sv
// Loop supervisor: resets an unstable loop, then lets it retry
`default_nettype none
module plwd_supv (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_enable,
  input  wire logic i_unstable,
  output logic      o_loop_reset,
  output logic      o_retry
);
  import plwd_pkg::*;

  typedef struct packed {
    plwd_supv_e       state;
    logic [CNT_W-1:0] cnt;
    logic             loop_reset;
    logic             retry;
  } plwd_supv_s;

  plwd_supv_s st_r;
  plwd_supv_s st_nxt;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.retry = 1'b0;
    case (st_r.state)
      SUPV_WATCH: begin
        if (i_enable && i_unstable) begin
          st_nxt.state      = SUPV_RESET;
          st_nxt.cnt        = '0;
          st_nxt.loop_reset = 1'b1;
        end
      end
      SUPV_RESET: begin
        if (st_r.cnt == (SUPV_RESET_CYC - ONE_CNT)) begin
          st_nxt.state      = SUPV_RETRY;
          st_nxt.loop_reset = 1'b0;
          st_nxt.retry      = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt + ONE_CNT;
        end
      end
      SUPV_RETRY: begin
        st_nxt.state = SUPV_WATCH;
      end
      default: begin
        st_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_loop_reset = st_r.loop_reset;
  assign o_retry      = st_r.retry;

  sequence s_reset_pulse;
    o_loop_reset [*8] ##1 (!o_loop_reset && o_retry);
  endsequence

  property p_reset_len;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(o_loop_reset) |-> s_reset_pulse;
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("loop reset pulse length wrong");

  property p_supv_start;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (st_r.state == SUPV_WATCH && i_enable && i_unstable) |=> $rose(o_loop_reset);
  endproperty
  a_supv_start: assert property (p_supv_start) else $error("unstable loop not reset");

  property p_supv_off;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !i_enable |=> !$rose(o_loop_reset);
  endproperty
  a_supv_off: assert property (p_supv_off) else $error("reset while supervisor off");
endmodule
`default_nettype wire

// ### rtl/plwd_top.sv
// Loop lock status, clock output pin and loop supervisor with register port
//
// Overview of operation
// - Lock status bit 0 reads one when locked.
// - Lock needs clock, settings, enable, settled loop.
// - Output config applies only on enable rising.
// - Rate code picks one, two, four, eight times.
// - Enable bit drives pin, otherwise released.
// - Enabled supervisor resets an unstable loop.
// - After reset, loop retries with same settings.
// - Predivider divides master clock by 1,2,4,8.
// - Loop disabled idles all dependent clocks.
//
// Local design decision: the plain strobed port.
`default_nettype none
module plwd_top (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst_n,
  input  wire plwd_pkg::plwd_bus_s      i_bus,
  output logic [plwd_pkg::DATA_W-1:0]   o_rd_data,
  input  wire plwd_pkg::plwd_loop_s     i_loop,
  input  wire logic [1:0]               i_predivider_code,
  input  wire logic                     i_master_clock_input,
  output logic                          o_loop_reference,
  output logic                          o_loop_reset,
  output logic                          o_loop_locked,
  output logic                          o_clock_output_pin,
  output logic                          o_clock_output_pin_oe,
  output logic                          o_irq
);
  import plwd_pkg::*;

  plwd_core_s       st_r;
  plwd_core_s       st_nxt;
  logic             loop_reset;
  logic             retry;
  logic             ref_pulse;
  logic             clk_wave;
  logic             clk_run;
  logic             mclk_tick;
  logic             qualify;
  logic             enable_rise;
  logic [CNT_W-1:0] pred_limit;
  logic [CNT_W-1:0] clk_limit;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clr;
  logic             wr_enable;
  logic             wr_clock_output_pin;
  logic             wr_supv;
  logic             wr_stat;
  logic             wr_mask;

  assign wr_enable   = i_bus.wr && (i_bus.addr == ADDR_LOOP_ENABLE);
  assign wr_clock_output_pin   = i_bus.wr && (i_bus.addr == ADDR_CLOCK_OUTPUT_PIN_CFG);
  assign wr_supv     = i_bus.wr && (i_bus.addr == ADDR_SUPV_CTRL);
  assign wr_stat     = i_bus.wr && (i_bus.addr == ADDR_IRQ_STATUS);
  assign wr_mask     = i_bus.wr && (i_bus.addr == ADDR_IRQ_MASK);
  assign enable_rise = wr_enable && !st_r.enable && i_bus.wdata[BIT_LOOP_ENABLE];

  // Master clock sampled as a synchronous level; a rising edge is one tick
  assign mclk_tick = i_master_clock_input && !st_r.mclk_prev;

  // Reference from the predivider: one tick per 1, 2, 4 or 8 master edges
  assign pred_limit = ONE_CNT << st_r.act_pred;

  // Half period shrinks by the rate code: x1, x2, x4, x8
  assign clk_limit = REF_HALF_CYC >> st_r.act_rate;
  assign clk_run   = st_r.enable && st_r.act_oe && !loop_reset;

  plwd_div u_prediv (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_run     (st_r.enable && !loop_reset),
    .i_tick    (mclk_tick),
    .i_limit   (pred_limit),
    .o_pulse   (ref_pulse),
    .o_wave    ()
  );

  plwd_div u_clock_output_pin (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_run     (clk_run),
    .i_tick    (1'b1),
    .i_limit   (clk_limit),
    .o_pulse   (),
    .o_wave    (clk_wave)
  );

  plwd_supv u_supv (
    .i_sys_clk    (i_sys_clk),
    .i_rst_n      (i_rst_n),
    .i_enable     (st_r.supv_en && st_r.enable),
    .i_unstable   (i_loop.unstable),
    .o_loop_reset (loop_reset),
    .o_retry      (retry)
  );

  // All four lock prerequisites, a stable loop, and no supervisor reset in progress
  assign qualify = st_r.enable && !loop_reset && i_loop.ref_present &&
                   i_loop.settings_ok && i_loop.settled && !i_loop.unstable;

  always_comb begin
    st_nxt           = st_r;
    st_nxt.mclk_prev = i_master_clock_input;
    events           = '0;
    clr              = '0;

    if (wr_enable) begin
      st_nxt.enable = i_bus.wdata[BIT_LOOP_ENABLE];
    end
    if (wr_clock_output_pin) begin
      st_nxt.pend_rate = i_bus.wdata[RATE_MSB:RATE_LSB];
      st_nxt.pend_oe   = i_bus.wdata[BIT_OUT_ENABLE];
    end
    // Staged settings go live only on the enable rising edge
    if (enable_rise) begin
      st_nxt.act_rate = st_r.pend_rate;
      st_nxt.act_oe   = st_r.pend_oe;
      st_nxt.act_pred = i_predivider_code;
    end
    if (wr_supv) begin
      st_nxt.supv_en = i_bus.wdata[BIT_SUPV_ENABLE];
    end
    if (wr_mask) begin
      st_nxt.mask = i_bus.wdata[IRQ_W-1:0];
    end

    // Lock after the loop has stayed qualified for the settle time
    if (!qualify) begin
      st_nxt.settle = '0;
      st_nxt.lock   = 1'b0;
    end else if (st_r.settle == LOCK_SETTLE_CYC) begin
      st_nxt.lock = 1'b1;
    end else begin
      st_nxt.settle = st_r.settle + ONE_CNT;
    end

    events[IRQ_LOCK_GAIN]  = st_nxt.lock && !st_r.lock;
    events[IRQ_LOCK_LOSS]  = !st_nxt.lock && st_r.lock;
    events[IRQ_SUPV_RESET] = retry;
    if (wr_stat) begin
      clr = i_bus.wdata[IRQ_W-1:0];
    end
    // A new event beats a same-cycle clear
    st_nxt.stat = (st_r.stat & ~clr) | events;
    st_nxt.irq  = |(st_nxt.stat & st_nxt.mask);

    // Pin driven only while the live enable bit is one
    st_nxt.oe = st_nxt.act_oe;

    st_nxt.rd_data = '0;
    if (i_bus.rd) begin
      case (i_bus.addr)
        ADDR_LOOP_ENABLE: st_nxt.rd_data[BIT_LOOP_ENABLE] = st_r.enable;
        ADDR_LOCK_STATUS: st_nxt.rd_data[BIT_LOCK] = st_r.lock;
        ADDR_CLOCK_OUTPUT_PIN_CFG: begin
          st_nxt.rd_data[RATE_MSB:RATE_LSB] = st_r.pend_rate;
          st_nxt.rd_data[BIT_OUT_ENABLE]    = st_r.pend_oe;
        end
        ADDR_SUPV_CTRL:  st_nxt.rd_data[BIT_SUPV_ENABLE] = st_r.supv_en;
        ADDR_IRQ_STATUS: st_nxt.rd_data[IRQ_W-1:0] = st_r.stat;
        ADDR_IRQ_MASK:   st_nxt.rd_data[IRQ_W-1:0] = st_r.mask;
        default:         st_nxt.rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r           <= '0;
      st_r.enable    <= RST_LOOP_ENABLE[BIT_LOOP_ENABLE];
      st_r.pend_rate <= RST_CLOCK_OUTPUT_PIN_CFG[RATE_MSB:RATE_LSB];
      st_r.pend_oe   <= RST_CLOCK_OUTPUT_PIN_CFG[BIT_OUT_ENABLE];
      st_r.act_rate  <= RST_CLOCK_OUTPUT_PIN_CFG[RATE_MSB:RATE_LSB];
      st_r.act_oe    <= RST_CLOCK_OUTPUT_PIN_CFG[BIT_OUT_ENABLE];
      st_r.supv_en   <= RST_SUPV_CTRL[BIT_SUPV_ENABLE];
      st_r.lock      <= RST_LOCK_STATUS[BIT_LOCK];
      st_r.stat      <= RST_IRQ;
      st_r.mask      <= RST_IRQ;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rd_data             = st_r.rd_data;
  assign o_loop_reference      = ref_pulse;
  assign o_loop_reset          = loop_reset;
  assign o_loop_locked         = st_r.lock;
  assign o_clock_output_pin    = clk_wave;
  assign o_clock_output_pin_oe = st_r.oe;
  assign o_irq                 = st_r.irq;

  property p_lock_read;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_bus.rd && i_bus.addr == ADDR_LOCK_STATUS) |=>
        (o_rd_data == {{(DATA_W-1){1'b0}}, $past(st_r.lock)});
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock read value wrong");

  property p_lock_qual;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(o_loop_locked) |-> ($past(qualify) && $past(st_r.settle) == LOCK_SETTLE_CYC);
  endproperty
  a_lock_qual: assert property (p_lock_qual) else $error("lock without settling");

  property p_cfg_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (wr_clock_output_pin && st_r.enable) |=> ##1 ($stable(st_r.act_rate) && $stable(st_r.act_oe));
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config applied early");

  property p_cfg_apply;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      enable_rise |=> ##1 (o_clock_output_pin_oe == $past(st_r.pend_oe, 2));
  endproperty
  a_cfg_apply: assert property (p_cfg_apply) else $error("pin enable not applied");

  sequence s_fast_high;
    o_clock_output_pin [*6] ##1 !o_clock_output_pin;
  endsequence

  // A stop or supervisor reset cuts the phase short on purpose
  property p_rate_x8;
    @(posedge i_sys_clk) disable iff (!i_rst_n || !clk_run)
      ($rose(o_clock_output_pin) && st_r.act_rate == 2'h3) |-> s_fast_high;
  endproperty
  a_rate_x8: assert property (p_rate_x8) else $error("x8 output phase length wrong");

  property p_idle;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (!st_r.enable) [*2] |-> (!o_clock_output_pin && !o_loop_reference);
  endproperty
  a_idle: assert property (p_idle) else $error("clock running while loop off");

  property p_ref_gated;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      o_loop_reference |-> $past(st_r.enable) && $past(mclk_tick);
  endproperty
  a_ref_gated: assert property (p_ref_gated) else $error("reference tick without edge");

  property p_irq_set_wins;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      events[IRQ_SUPV_RESET] |=> st_r.stat[IRQ_SUPV_RESET];
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins) else $error("status event lost");

  // Register port and staged settings
  property p_rd_idle;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !i_bus.rd |=> (o_rd_data == '0);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");

  property p_enable_write;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      wr_enable |=> (st_r.enable == $past(i_bus.wdata[BIT_LOOP_ENABLE]));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable not written");

  property p_supv_write;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      wr_supv |=> (st_r.supv_en == $past(i_bus.wdata[BIT_SUPV_ENABLE]));
  endproperty
  a_supv_write: assert property (p_supv_write) else $error("supervisor bit lost");

  property p_cfg_stage;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      wr_clock_output_pin |=> (st_r.pend_rate == $past(i_bus.wdata[RATE_MSB:RATE_LSB]) &&
                     st_r.pend_oe == $past(i_bus.wdata[BIT_OUT_ENABLE]));
  endproperty
  a_cfg_stage: assert property (p_cfg_stage) else $error("config not staged");

  property p_cfg_live;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      enable_rise |=> (st_r.act_rate == $past(st_r.pend_rate) &&
                       st_r.act_pred == $past(i_predivider_code));
  endproperty
  a_cfg_live: assert property (p_cfg_live) else $error("config not applied");

  property p_no_apply;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !enable_rise |=> ($stable(st_r.act_rate) && $stable(st_r.act_oe) &&
                        $stable(st_r.act_pred));
  endproperty
  a_no_apply: assert property (p_no_apply) else $error("config changed without rise");

  // Lock qualification
  property p_settle_count;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (qualify && st_r.settle != LOCK_SETTLE_CYC) |=>
        (st_r.settle == $past(st_r.settle) + ONE_CNT);
  endproperty
  a_settle_count: assert property (p_settle_count) else $error("settle count skipped");

  property p_lock_past;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      o_loop_locked |-> $past(qualify);
  endproperty
  a_lock_past: assert property (p_lock_past) else $error("lock held without qualify");

  property p_lock_drop;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !qualify |=> !o_loop_locked;
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("lock kept after drop");

  property p_gain_event;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(o_loop_locked) |-> st_r.stat[IRQ_LOCK_GAIN];
  endproperty
  a_gain_event: assert property (p_gain_event) else $error("lock gain not flagged");

  property p_w1c;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (wr_stat && i_bus.wdata[IRQ_LOCK_LOSS] && !events[IRQ_LOCK_LOSS]) |=>
        !st_r.stat[IRQ_LOCK_LOSS];
  endproperty
  a_w1c: assert property (p_w1c) else $error("status not cleared");

  // Gating of the dependent clocks
  property p_pin_stop;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !clk_run |=> !o_clock_output_pin;
  endproperty
  a_pin_stop: assert property (p_pin_stop) else $error("pin toggles while stopped");

  property p_ref_reset;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      loop_reset |=> !o_loop_reference;
  endproperty
  a_ref_reset: assert property (p_ref_reset) else $error("reference during loop reset");

  property p_reset_unlock;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      o_loop_reset |=> !o_loop_locked;
  endproperty
  a_reset_unlock: assert property (p_reset_unlock) else $error("lock during loop reset");
endmodule
`default_nettype wire

// ### testbench/plwd_listener.sv
// Far-side audio device model: measures the clock it receives on the output pin
`default_nettype none
module plwd_listener (
  input  wire logic i_sys_clk,
  input  wire logic i_pin,
  input  wire logic i_pin_oe,
  output int        o_period,
  output int        o_rises
);
  timeunit 1ns;
  timeprecision 1ps;
  logic line = 1'b1;
  logic prev = 1'b1;
  logic drv  = 1'b0;
  int   cnt  = 0;
  int   last = 0;
  int   per  = 0;
  int   nr   = 0;
  assign o_period = per;
  assign o_rises  = nr;
  // Period between rising edges, sampled mid-cycle clear of the launching edge
  always @(negedge i_sys_clk) begin
    cnt++;
    // Released pin has no pull: it shows the inverse of the last driven level
    line = i_pin_oe ? i_pin : ~drv;
    if (i_pin_oe) drv = i_pin;
    if (line === 1'b1 && prev === 1'b0) begin
      per = cnt - last;
      last = cnt;
      nr++;
    end
    prev = line;
  end
endmodule
`default_nettype wire

// ### testbench/plwd_top_tb_top.sv
// Self-checking bench of the lock flag, clock output pin and loop supervisor
`default_nettype none
module plwd_top_tb_top;
  import plwd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  plwd_bus_s bus = '0;
  plwd_loop_s loop = '{1'b1, 1'b1, 1'b1, 1'b0};
  logic [1:0] pcode = 2'h0;
  logic mclk = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic lref, lrst, locked, pin, pin_oe, irq;
  int errors = 0;
  int num_checks = 0;
  int period, rises, nref, t;
  int mdl[int];
  logic [31:0] seed = 32'h41fe93e8;
  logic [DATA_W-1:0] v;
  logic [ADDR_W-1:0] addrs [7] = '{ADDR_LOOP_ENABLE, ADDR_LOCK_STATUS, ADDR_CLOCK_OUTPUT_PIN_CFG,
                                   ADDR_SUPV_CTRL, ADDR_IRQ_STATUS, ADDR_IRQ_MASK, 16'h1234};

  always #4 i_sys_clk = ~i_sys_clk;
  // Master clock: one rising edge every four system clocks
  always @(posedge i_sys_clk) begin
    t++;
    if (t % 2 == 0) mclk <= ~mclk;
  end
  always @(negedge i_sys_clk) if (lref === 1'b1) nref++;

  plwd_top i_plwd_top (
    .i_sys_clk            (i_sys_clk),
    .i_rst_n              (i_rst_n),
    .i_bus                (bus),
    .o_rd_data            (rd_data),
    .i_loop               (loop),
    .i_predivider_code    (pcode),
    .i_master_clock_input (mclk),
    .o_loop_reference     (lref),
    .o_loop_reset         (lrst),
    .o_loop_locked        (locked),
    .o_clock_output_pin   (pin),
    .o_clock_output_pin_oe(pin_oe),
    .o_irq                (irq)
  );
  plwd_listener i_plwd_listener (
    .i_sys_clk(i_sys_clk),
    .i_pin    (pin),
    .i_pin_oe (pin_oe),
    .o_period (period),
    .o_rises  (rises)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string name, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_rng(input string name, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_sys_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_sys_clk);
    bus.wr <= 1'b0;
    case (a)
      ADDR_LOOP_ENABLE, ADDR_SUPV_CTRL: mdl[a] = d & 16'h0001;
      ADDR_CLOCK_OUTPUT_PIN_CFG, ADDR_IRQ_MASK:  mdl[a] = d & 16'h0007;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge i_sys_clk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge i_sys_clk);
    bus.rd <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] d;
    rd(a, d);
    check($sformatf("reg %h", a), mdl.exists(a) ? mdl[a][DATA_W-1:0] : 16'h0000, d);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wait_lock(output int n);
    n = 0;
    while (locked !== 1'b1 && n < 400) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    check("lock wait", 16'h0001, {15'h0000, locked});
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #200us;
    errors++;
    print_verdict();
  end

  initial begin
    int n;
    mdl[ADDR_SUPV_CTRL] = 1;
    repeat (8) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    foreach (addrs[i]) rd_chk(addrs[i]);
    seed = lfsr(seed);
    wr(ADDR_IRQ_MASK, seed[15:0] | 16'h0007);
    seed = lfsr(seed);
    wr(ADDR_CLOCK_OUTPUT_PIN_CFG, (seed[15:0] & 16'hfff8) | 16'h0007);
    wr(16'h1234, seed[15:0]);
    wr(ADDR_LOCK_STATUS, 16'hffff);
    rd_chk(ADDR_CLOCK_OUTPUT_PIN_CFG);
    rd_chk(ADDR_IRQ_MASK);
    rd_chk(16'h1234);
    cycles(3);
    check("oe staged", 1'b0, pin_oe);
    wr(ADDR_LOOP_ENABLE, 16'h0001);
    wait_lock(n);
    check_rng("lock delay", 124, 130, n);
    mdl[ADDR_LOCK_STATUS] = 1;
    rd_chk(ADDR_LOCK_STATUS);
    rd(ADDR_IRQ_STATUS, v);
    check("gain status", 16'h0001, v & 16'h0001);
    check("irq", 1'b1, irq);
    @(posedge i_sys_clk);
    loop.settled <= 1'b0;
    cycles(3);
    check("lock drop", 1'b0, locked);
    @(posedge i_sys_clk);
    loop.settled <= 1'b1;
    wait_lock(n);
    rd(ADDR_IRQ_STATUS, v);
    check("loss status", 16'h0002, v & 16'h0002);
    cycles(40);
    check("oe on", 1'b1, pin_oe);
    check_rng("period r3", 12, 12, period);
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_LOOP_ENABLE, 16'h0000);
      cycles(3);
      n = rises;
      cycles(100);
      check("pin idle", 1'b0, pin);
      check_rng("no edges", n, n, rises);
      wr(ADDR_CLOCK_OUTPUT_PIN_CFG, 16'((r << 1) | 1));
      pcode <= 2'(r);
      wr(ADDR_LOOP_ENABLE, 16'h0001);
      cycles(250);
      check_rng("period", 96 >> r, 96 >> r, period);
      nref = 0;
      cycles(256);
      check_rng("reference", (64 >> r) - 1, (64 >> r) + 1, nref);
    end
    wr(ADDR_CLOCK_OUTPUT_PIN_CFG, 16'h0000);
    cycles(20);
    check("oe live", 1'b1, pin_oe);
    wr(ADDR_LOOP_ENABLE, 16'h0000);
    wr(ADDR_LOOP_ENABLE, 16'h0001);
    cycles(3);
    check("oe off", 1'b0, pin_oe);
    wait_lock(n);
    wr(ADDR_IRQ_STATUS, 16'h0007);
    cycles(2);
    check("irq clear", 1'b0, irq);
    @(posedge i_sys_clk);
    loop.unstable <= 1'b1;
    @(posedge i_sys_clk);
    loop.unstable <= 1'b0;
    n = 0;
    #1;
    while (lrst === 1'b1 && n < 20) begin
      n++;
      cycles(1);
    end
    check_rng("reset width", 8, 8, n);
    rd(ADDR_IRQ_STATUS, v);
    check("supv status", 16'h0004, v & 16'h0004);
    wait_lock(n);
    check("relock", 1'b1, locked);
    wr(ADDR_IRQ_MASK, 16'h0000);
    cycles(2);
    check("irq masked", 1'b0, irq);
    wr(ADDR_SUPV_CTRL, 16'h0000);
    rd_chk(ADDR_SUPV_CTRL);
    @(posedge i_sys_clk);
    loop.unstable <= 1'b1;
    n = 0;
    repeat (20) begin
      cycles(1);
      if (lrst === 1'b1) n++;
    end
    @(posedge i_sys_clk);
    loop.unstable <= 1'b0;
    check_rng("no supervision", 0, 0, n);
    print_verdict();
  end
endmodule
`default_nettype wire
